// ### hw/ciex_pkg.sv
package ciex_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // bus map, byte addresses
   localparam logic [11:0] OFF_INSTR  = 12'h000;
   localparam logic [11:0] OFF_ACC    = 12'h004;
   localparam logic [11:0] OFF_STATUS = 12'h008;
   localparam logic [11:0] OFF_CTRL   = 12'h00C;
   localparam logic [11:0] OFF_PC     = 12'h010;
   localparam logic [11:0] OFF_CYCLES = 12'h014;
   localparam logic [2:0]  FILE_SEL   = 3'h1;

   ////////////////////////////////////////////////////////////////////////////////
   // field positions
   localparam int unsigned STATUS_C_BIT   = 0;
   localparam int unsigned STATUS_DC_BIT  = 1;
   localparam int unsigned STATUS_Z_BIT   = 2;
   localparam int unsigned STATUS_SKIP_BIT = 3;
   localparam int unsigned STATUS_ILL_BIT = 4;
   localparam int unsigned CTRL_PSA_BIT   = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // instruction classes and operation codes
   localparam logic [1:0] CLS_BYTE    = 2'h0;
   localparam logic [1:0] CLS_BIT     = 2'h1;
   localparam logic [1:0] CLS_LIT     = 2'h3;
   localparam logic [3:0] OP_ADD_FILE = 4'h7;
   localparam logic [3:0] OP_AND_FILE = 4'h5;
   localparam logic [3:0] OP_MOVE_FILE = 4'h8;
   localparam logic [2:0] OP_ADD_LIT_HI = 3'h7;
   localparam logic [3:0] OP_AND_LIT  = 4'h9;
   localparam logic [1:0] BIT_CLEAR   = 2'h0;
   localparam logic [1:0] BIT_SET     = 2'h1;
   localparam logic [1:0] BIT_SKIP_SET = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // reset values and responses
   localparam logic [7:0]  RST_BYTE    = 8'h00;
   localparam logic [13:0] RST_INSTR   = 14'h0000;
   localparam logic [31:0] RST_WORD    = 32'h00000000;
   localparam logic [1:0]  RESP_OKAY   = 2'h0;
   localparam logic [1:0]  RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic [1:0] cls;
      logic [3:0] op;
      logic       dest;
      logic [6:0] file;
   } ciex_word_t;

   typedef struct packed {
      logic z;
      logic dc;
      logic c;
   } ciex_flags_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_EXEC = 3'b010,
      ST_RESP = 3'b100
   } ciex_state_t;

endpackage

// ### hw/ciex_core.sv
// What this block does
// - read-modify-write of port uses pin levels
// - result written to timer clears prescaler
// - taken test costs extra no-operation cycle
// - add literal to accumulator, set C DC Z
// - add accumulator and file register, C DC Z
// - destination bit picks accumulator or file
// - bit clear touches one bit, no flags
// - bit set touches one bit, no flags
// - and literal into accumulator, Z only
// - bit set skips next instruction, no flags
// - and with file register, Z only
//
// Added by the designer: register access over AXI4-Lite and the address map.
`timescale 1ns/1ps
module ciex_core
   import ciex_pkg::*;
#(
   parameter int unsigned FILE_DEPTH = 128,
   parameter int unsigned PIN_W      = 8,
   parameter int unsigned PC_W       = 13,
   parameter logic [6:0]  PORT_ADDR  = 7'h05,
   parameter logic [6:0]  TIMER_ADDR = 7'h01
) (
   // clock and reset
   input  wire logic             aclk,
   input  wire logic             aresetn,
   // write address
   input  wire logic [11:0]      awaddr,
   input  wire logic [2:0]       awprot,
   input  wire logic             awvalid,
   output logic                  awready,
   // write data
   input  wire logic [31:0]      wdata,
   input  wire logic [3:0]       wstrb,
   input  wire logic             wvalid,
   output logic                  wready,
   // write response
   output logic [1:0]            bresp,
   output logic                  bvalid,
   input  wire logic             bready,
   // read address
   input  wire logic [11:0]      araddr,
   input  wire logic [2:0]       arprot,
   input  wire logic             arvalid,
   output logic                  arready,
   // read data
   output logic [31:0]           rdata,
   output logic [1:0]            rresp,
   output logic                  rvalid,
   input  wire logic             rready,
   // port pins and timer side
   input  wire logic [PIN_W-1:0] port_pins,
   output logic [PIN_W-1:0]      port_out,
   output logic                  prescaler_clear
);

   ////////////////////////////////////////////////////////////////////////////////
   // state
   ciex_state_t      state;
   ciex_word_t       instr;
   ciex_flags_t      flags, next_flags;
   logic [7:0]       regs [FILE_DEPTH];
   logic [7:0]       acc, next_acc, opnd, src, lit, res;
   logic [PIN_W-1:0] pin_meta, pin_sync;
   logic [PC_W-1:0]  program_counter;
   logic [31:0]      cycles, wd, rd_word;
   logic [11:0]      wa;
   logic [8:0]       sum9;
   logic [6:0]       bus_idx;
   logic [4:0]       nib;
   logic [3:0]       ws;
   logic [2:0]       bit_idx;
   logic             psa, skip_pending, next_skip, illegal, next_illegal, exec;
   logic             aw_got, w_got, bus_wr, bus_file, bus_hit, rd_hit, to_dest, wr_file;

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchroniser, no reset: it only ever holds sampled pin levels
   always_ff @(posedge aclk) begin
      pin_meta <= port_pins;
      pin_sync <= pin_meta;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi write channel
   assign bus_wr   = (state == ST_IDLE) && aw_got && w_got;
   assign bus_file = (wa[11:9] == FILE_SEL);
   assign bus_idx  = wa[8:2];
   assign bus_hit  = bus_file || (wa == OFF_INSTR) || (wa == OFF_ACC) ||
                     (wa == OFF_STATUS) || (wa == OFF_CTRL);
   assign exec     = (state == ST_EXEC);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready <= 1'b0;
         wready  <= 1'b0;
         aw_got  <= 1'b0;
         w_got   <= 1'b0;
         wa      <= 12'h000;
         wd      <= RST_WORD;
         ws      <= 4'h0;
      end else begin
         // ready is a one-cycle pulse so each channel is taken exactly once
         awready <= !aw_got && awvalid && !awready && (state == ST_IDLE);
         wready  <= !w_got && wvalid && !wready && (state == ST_IDLE);
         if (awvalid && awready) begin
            aw_got <= 1'b1;
            wa     <= {awaddr[11:2], 2'b00};
         end
         if (wvalid && wready) begin
            w_got <= 1'b1;
            wd    <= wdata;
            ws    <= wstrb;
         end
         if (bvalid && bready) begin
            aw_got <= 1'b0;
            w_got  <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state  <= ST_IDLE;
         bvalid <= 1'b0;
         bresp  <= RESP_OKAY;
      end else begin
         case (state)
            ST_IDLE: begin
               if (bus_wr) begin
                  bresp <= bus_hit ? RESP_OKAY : RESP_SLVERR;
                  state <= (wa == OFF_INSTR && ws[1:0] == 2'h3) ? ST_EXEC : ST_RESP;
               end
            end
            ST_EXEC: state <= ST_RESP;
            ST_RESP: begin
               bvalid <= 1'b1;
               if (bvalid && bready) begin
                  bvalid <= 1'b0;
                  state  <= ST_IDLE;
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // execute
   always_comb begin
      opnd = (instr.file == PORT_ADDR) ? pin_sync[7:0] : regs[instr.file];
      lit          = {instr.dest, instr.file};
      src          = (instr.cls == CLS_LIT) ? lit : opnd;
      bit_idx      = {instr.op[1:0], instr.dest};
      sum9         = {1'b0, acc} + {1'b0, src};
      nib          = {1'b0, acc[3:0]} + {1'b0, src[3:0]};
      res          = RST_BYTE;
      to_dest      = 1'b0;
      wr_file      = 1'b0;
      next_acc     = acc;
      next_flags   = flags;
      next_skip    = 1'b0;
      next_illegal = illegal;
      // a skipped word is consumed as a no-operation
      if (!skip_pending) begin
         case (instr.cls)
            CLS_BYTE: begin
               case (instr.op)
                  OP_ADD_FILE: begin
                     res          = sum9[7:0];
                     next_flags.c  = sum9[8];
                     next_flags.dc = nib[4];
                     to_dest      = 1'b1;
                  end
                  OP_AND_FILE: begin
                     res     = acc & opnd;
                     to_dest = 1'b1;
                  end
                  OP_MOVE_FILE: begin
                     res     = opnd;
                     to_dest = 1'b1;
                  end
                  default: begin
                     next_illegal = 1'b1;
                  end
               endcase
               if (to_dest) begin
                  next_flags.z = (res == RST_BYTE);
                  wr_file      = instr.dest;
                  next_acc     = instr.dest ? acc : res;
               end
            end
            CLS_BIT: begin
               case (instr.op[3:2])
                  BIT_CLEAR: begin
                     res     = opnd & ~(8'h01 << bit_idx);
                     wr_file = 1'b1;
                  end
                  BIT_SET: begin
                     res     = opnd | (8'h01 << bit_idx);
                     wr_file = 1'b1;
                  end
                  BIT_SKIP_SET: begin
                     next_skip = opnd[bit_idx];
                  end
                  default: begin
                     next_illegal = 1'b1;
                  end
               endcase
            end
            CLS_LIT: begin
               if (instr.op[3:1] == OP_ADD_LIT_HI) begin
                  next_acc      = sum9[7:0];
                  next_flags.c  = sum9[8];
                  next_flags.dc = nib[4];
                  next_flags.z  = (sum9[7:0] == RST_BYTE);
               end else if (instr.op == OP_AND_LIT) begin
                  next_acc     = acc & lit;
                  next_flags.z = ((acc & lit) == RST_BYTE);
               end else begin
                  next_illegal = 1'b1;
               end
            end
            default: begin
               next_illegal = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         instr        <= RST_INSTR;
         acc          <= RST_BYTE;
         flags        <= '0;
         psa          <= 1'b0;
         skip_pending <= 1'b0;
         illegal      <= 1'b0;
      end else if (exec) begin
         acc          <= next_acc;
         flags        <= next_flags;
         skip_pending <= next_skip;
         illegal      <= next_illegal;
      end else if (bus_wr) begin
         if (wa == OFF_INSTR && ws[1:0] == 2'h3) instr <= wd[13:0];
         if (wa == OFF_ACC && ws[0]) acc <= wd[7:0];
         if (wa == OFF_STATUS && ws[0]) begin
            flags   <= wd[STATUS_Z_BIT:STATUS_C_BIT];
            illegal <= wd[STATUS_ILL_BIT];
         end
         if (wa == OFF_CTRL && ws[0]) psa <= wd[CTRL_PSA_BIT];
      end
   end

   // one count per instruction cycle, skipped words included
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         program_counter <= '0;
         cycles          <= RST_WORD;
      end else if (exec) begin
         program_counter <= program_counter + 1'b1;
         cycles          <= cycles + 32'h00000001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         prescaler_clear <= 1'b0;
      end else begin
         prescaler_clear <= exec && wr_file && (instr.file == TIMER_ADDR) && psa;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // register file and port latch
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < FILE_DEPTH; i++) begin
            regs[i] <= RST_BYTE;
         end
         port_out <= '0;
      end else if (exec && wr_file) begin
         regs[instr.file] <= res;
         if (instr.file == PORT_ADDR) begin
            port_out <= res[PIN_W-1:0];
         end
      end else if (bus_wr && bus_file && ws[0]) begin
         regs[bus_idx] <= wd[7:0];
         if (bus_idx == PORT_ADDR) begin
            port_out <= wd[PIN_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // axi read channel
   always_comb begin
      rd_word = RST_WORD;
      rd_hit  = 1'b1;
      if (araddr[11:9] == FILE_SEL) begin
         // the port reads as its pins, just as the core sees it
         rd_word[7:0] = (araddr[8:2] == PORT_ADDR) ? pin_sync[7:0] : regs[araddr[8:2]];
      end else begin
         case ({araddr[11:2], 2'b00})
            OFF_INSTR:  rd_word[13:0] = instr;
            OFF_ACC:    rd_word[7:0]  = acc;
            OFF_STATUS: rd_word[4:0]  = {illegal, skip_pending, flags};
            OFF_CTRL:   rd_word[0]    = psa;
            OFF_PC:     rd_word[PC_W-1:0] = program_counter;
            OFF_CYCLES: rd_word       = cycles;
            default:    rd_hit        = 1'b0;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= RST_WORD;
         rresp   <= RESP_OKAY;
      end else begin
         arready <= arvalid && !arready && !rvalid;
         if (arvalid && arready) begin
            rvalid <= 1'b1;
            rdata  <= rd_word;
            rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         end else if (rvalid && rready) begin
            rvalid <= 1'b0;
         end
      end
   end

endmodule // ciex_core

// ### test/ciex_core_properties.sv
`timescale 1ns/1ps
module ciex_core_properties
   import ciex_pkg::*;
(
   // clock and reset
   input wire logic       aclk,
   input wire logic       aresetn,
   // write side
   input wire logic       awvalid,
   input wire logic       awready,
   input wire logic       wready,
   input wire logic [1:0] bresp,
   input wire logic       bvalid,
   input wire logic       bready,
   // read side
   input wire logic       arvalid,
   input wire logic       arready,
   input wire logic       rvalid,
   input wire logic       rready,
   // timer side
   input wire logic       prescaler_clear
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////
   a_one_bresp: assert property (bvalid && bready |=> !bvalid)
      else $error("write answered twice");
   a_one_rresp: assert property (rvalid && rready |=> !rvalid)
      else $error("read answered twice");
   a_ar_refused: assert property (rvalid |-> !arready)
      else $error("read taken while answer pending");
   a_aw_refused: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read answer late");
   a_write_answer: assert property (awvalid && awready |-> ##[1:4] bvalid)
      else $error("write answer late");
   a_clear_pulse: assert property (prescaler_clear |=> !prescaler_clear)
      else $error("prescaler clear longer than one cycle");
   a_clear_resp: assert property (prescaler_clear |=> $rose(bvalid))
      else $error("prescaler clear outside instruction result");
   c_clear: cover property (prescaler_clear);
   c_slverr: cover property (bvalid && bresp == RESP_SLVERR);
   c_read: cover property (rvalid && rready);
endmodule // ciex_core_properties

// ### test/ciex_pin_model.sv
`timescale 1ns/1ps
module ciex_pin_model (
   // output latch from the core
   input  wire logic [7:0] port_out,
   // outside device pulling pins low
   input  wire logic [7:0] ext_low,
   // pin levels back to the core
   output logic      [7:0] port_pins
);
   // an outside driver beats the latch, so pins may differ from it
   assign port_pins = port_out & ~ext_low;
endmodule // ciex_pin_model

// ### test/cpu_instruction_execute_subset_test.sv
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
   $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module cpu_instruction_execute_subset_test
   import ciex_pkg::*;
;
   logic        aclk, aresetn, awvalid, wvalid, arvalid;
   logic        awready, wready, bvalid, arready, rvalid, prescaler_clear;
   logic [11:0] awaddr, araddr;
   logic [31:0] wdata, rdata, ra, rf, rs, pc0, pc1;
   logic [1:0]  bresp, rresp, rsp;
   logic [7:0]  port_pins, port_out, ext_low;
   logic [10:0] x;
   int          num_errors, compares, cycles, pulses;
   localparam logic [6:0] PORT_ADDR  = 7'h05;
   localparam logic [6:0] TIMER_ADDR = 7'h01;

   ciex_core #(.PORT_ADDR(PORT_ADDR), .TIMER_ADDR(TIMER_ADDR))
      u_dut (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready,
      .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1),
      .araddr, .arprot(3'h0), .arvalid, .arready, .rdata, .rresp, .rvalid,
      .rready(1'b1), .port_pins, .port_out, .prescaler_clear);
   ciex_pin_model u_pins (.port_out, .ext_low, .port_pins);

   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   always @(posedge aclk) begin
      cycles++;
      if (prescaler_clear === 1'b1) pulses++;
      if (cycles == 6000) begin
         num_errors++;
         report_and_stop();
      end
   end
   ////////////////////////////////////////
   // ready lines stay high: no stall, answers are taken at once
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      awaddr  <= a;
      wdata   <= d;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      rsp = bresp;
   endtask
   task automatic rd(input logic [11:0] a, output logic [31:0] d);
      araddr  <= a;
      arvalid <= 1'b1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      d   = rdata;
      rsp = rresp;
   endtask
   function automatic logic [11:0] fad(input logic [6:0] f);
      return 12'h200 + {3'h0, f, 2'h0};
   endfunction
   function automatic logic [10:0] addx(input logic [7:0] a, input logic [7:0] k);
      logic [8:0] s;
      logic [4:0] h;
      s = {1'b0, a} + {1'b0, k};
      h = {1'b0, a[3:0]} + {1'b0, k[3:0]};
      return {s[7:0] == 8'h00, h[4], s[8], s[7:0]};
   endfunction
   // preload acc, file and flags, run one word, read all three back
   task automatic op(input logic [6:0] f, input logic [7:0] a0, input logic [7:0] f0,
                     input logic [2:0] s0, input logic [13:0] w);
      wr(OFF_ACC, {24'h0, a0});
      wr(fad(f), {24'h0, f0});
      wr(OFF_STATUS, {29'h0, s0});
      wr(OFF_INSTR, {18'h0, w});
      rd(OFF_ACC, ra);
      rd(fad(f), rf);
      rd(OFF_STATUS, rs);
   endtask
   ////////////////////////////////////////
   task automatic t_reset();
      rd(OFF_STATUS, rs);
      `CHK(rs, RST_WORD)
      rd(12'hFFC, ra);
      `CHK(rsp, RESP_SLVERR)
      `CHK(ra, RST_WORD)
      wr(12'hFF8, 32'h1);
      `CHK(rsp, RESP_SLVERR)
   endtask
   task automatic t_add();
      logic [7:0] av [4] = '{8'h0F, 8'hF0, 8'h01, 8'hFF};
      logic [7:0] kv [4] = '{8'h01, 8'h10, 8'h02, 8'hFF};
      for (int i = 0; i < 4; i++) begin
         x = addx(av[i], kv[i]);
         op(7'h20, av[i], 8'h5A, 3'h0, {CLS_LIT, OP_ADD_LIT_HI, 1'b0, kv[i]});
         `CHK(ra[7:0], x[7:0])
         `CHK(rs[2:0], x[10:8])
         op(7'h7F, av[i], kv[i], 3'h0, {CLS_BYTE, OP_ADD_FILE, i[0], 7'h7F});
         `CHK(i[0] ? rf[7:0] : ra[7:0], x[7:0])
         `CHK(i[0] ? ra[7:0] : rf[7:0], i[0] ? av[i] : kv[i])
         `CHK(rs[2:0], x[10:8])
      end
   endtask
   task automatic t_and();
      op(7'h20, 8'hF0, 8'h3C, 3'h3, {CLS_LIT, OP_AND_LIT, 8'h0F});
      `CHK(ra[7:0], 8'h00)
      `CHK(rs[2:0], 3'h7)
      op(7'h20, 8'hF0, 8'h3C, 3'h7, {CLS_BYTE, OP_AND_FILE, 1'b1, 7'h20});
      `CHK(rf[7:0], 8'h30)
      `CHK(ra[7:0], 8'hF0)
      `CHK(rs[2:0], 3'h3)
      op(7'h20, 8'hF0, 8'h3C, 3'h0, {CLS_BYTE, OP_AND_FILE, 1'b0, 7'h20});
      `CHK(ra[7:0], 8'h30)
      `CHK(rf[7:0], 8'h3C)
      op(7'h20, 8'hF0, 8'h00, 3'h3, {CLS_BYTE, OP_MOVE_FILE, 1'b0, 7'h20});
      `CHK(ra[7:0], 8'h00)
      `CHK(rs[2:0], 3'h7)
   endtask
   task automatic t_bits();
      for (int b = 0; b < 8; b++) begin
         op(7'h20, 8'h00, 8'h00, 3'h7, {CLS_BIT, BIT_SET, b[2:0], 7'h20});
         `CHK(rf[7:0], 8'h01 << b)
         `CHK(rs[2:0], 3'h7)
         op(7'h20, 8'h00, 8'hFF, 3'h0, {CLS_BIT, BIT_CLEAR, b[2:0], 7'h20});
         `CHK(rf[7:0], ~(8'h01 << b))
         `CHK(rs[2:0], 3'h0)
      end
   endtask
   task automatic t_skip();
      rd(OFF_PC, pc0);
      op(7'h20, 8'h11, 8'h82, 3'h7, {CLS_BIT, BIT_SKIP_SET, 3'h1, 7'h20});
      `CHK(rs[3], 1'b1)
      `CHK(rs[2:0], 3'h7)
      op(7'h20, 8'h11, 8'h82, 3'h0, {CLS_LIT, OP_ADD_LIT_HI, 1'b0, 8'h01});
      `CHK(ra[7:0], 8'h11)
      `CHK(rs[3], 1'b0)
      rd(OFF_PC, pc1);
      `CHK(pc1 - pc0, 32'h2)
      op(7'h20, 8'h11, 8'h82, 3'h0, {CLS_BIT, BIT_SKIP_SET, 3'h0, 7'h20});
      `CHK(rs[3], 1'b0)
      op(7'h20, 8'h11, 8'h82, 3'h0, {CLS_LIT, OP_ADD_LIT_HI, 1'b0, 8'h01});
      `CHK(ra[7:0], 8'h12)
   endtask
   task automatic t_port();
      ext_low <= 8'h01;
      op(PORT_ADDR, 8'h00, 8'hFF, 3'h0, {CLS_BIT, BIT_SET, 3'h7, PORT_ADDR});
      `CHK(port_out, 8'hFE)
      `CHK(rf[7:0], 8'hFE)
      ext_low <= 8'h00;
   endtask
   task automatic t_timer();
      logic [1:0] cv [3] = '{2'b11, 2'b10, 2'b01};
      int p;
      for (int i = 0; i < 3; i++) begin
         wr(OFF_CTRL, {31'h0, cv[i][1]});
         p = pulses;
         op(TIMER_ADDR, 8'h01, 8'h02, 3'h0, {CLS_BYTE, OP_ADD_FILE, cv[i][0], TIMER_ADDR});
         `CHK(pulses - p, (i == 0) ? 1 : 0)
      end
   endtask
   task automatic report_and_stop();
      $display("errors=%0d compares=%0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      aresetn = 1'b0;
      awvalid = 1'b0;
      wvalid  = 1'b0;
      arvalid = 1'b0;
      awaddr  = 12'h000;
      araddr  = 12'h000;
      wdata   = 32'h00000000;
      ext_low = 8'h00;
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_add();
      t_and();
      t_bits();
      t_skip();
      t_port();
      t_timer();
      report_and_stop();
   end
endmodule // cpu_instruction_execute_subset_test

bind ciex_core ciex_core_properties u_props (.aclk, .aresetn, .awvalid, .awready, .wready,
   .bresp, .bvalid, .bready, .arvalid, .arready, .rvalid, .rready, .prescaler_clear);
